// ===== common/sst_pkg.sv
package sst_pkg;

  // Default word width and FIFO depth.
  localparam int          DEF_WORD_W     = 16;
  localparam int          DEF_FIFO_DEPTH = 4;

  // Register byte offsets.
  localparam logic [7:0]  ADDR_CTRL      = 8'h00;
  localparam logic [7:0]  ADDR_DATA      = 8'h04;
  localparam logic [7:0]  ADDR_STATUS    = 8'h08;
  localparam logic [7:0]  ADDR_MASK      = 8'h0c;

  // Control register fields.
  localparam int          CTRL_FRAMING   = 0;
  localparam int          CTRL_SYNC_SRC  = 1;
  localparam int          CTRL_CLK_SRC   = 2;
  localparam int          CTRL_TRANSMITTER_RESET_N_N    = 3;
  localparam int          CTRL_W         = 4;
  localparam logic [3:0]  CTRL_RESET     = 4'h0;

  // Status and mask fields; events are sticky and cleared by writing one.
  localparam int          EVT_EMPTY      = 0;
  localparam int          EVT_DROP       = 1;
  localparam int          EVT_W          = 2;
  localparam logic [1:0]  EVT_RESET      = 2'h0;
  localparam int          STAT_COUNT_LSB = 4;
  localparam int          STAT_BUSY      = 8;

  // Engine states.
  typedef enum logic [1:0] {ST_IDLE, ST_SYNC, ST_ARMED, ST_SHIFT} tx_state_t;

endpackage

// ===== hw/sync_serial_transmitter.sv
// The APB interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/100ps
module sync_serial_transmitter
  import sst_pkg::*;
#(
  parameter int WORD_W     = DEF_WORD_W,
  parameter int FIFO_DEPTH = DEF_FIFO_DEPTH
)
(
  // System clock and reset.
  input  wire logic        clk,
  input  wire logic        reset_n,
  // APB slave.
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Serial pins.
  input  wire logic        transmit_bit_clock_in,
  output logic             transmit_bit_clock_out,
  output logic             transmit_bit_clock_oe,
  input  wire logic        transmit_frame_sync_in,
  output logic             transmit_frame_sync_out,
  output logic             transmit_frame_sync_oe,
  output logic             transmit_data_out,
  // Interrupt.
  output logic             transmit_interrupt
);

  localparam int PTR_W = $clog2(FIFO_DEPTH);
  localparam int CNT_W = $clog2(FIFO_DEPTH + 1);
  localparam int BIT_W = $clog2(WORD_W);
  localparam logic [BIT_W-1:0] BIT_LAST = BIT_W'(WORD_W - 1);
  localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(FIFO_DEPTH);

  // Depth must be a power of two for wrapping pointers; words fit the data bus.
  if (FIFO_DEPTH < 2 || (FIFO_DEPTH & (FIFO_DEPTH - 1)) != 0 || WORD_W < 2 || WORD_W > 32)
  begin : g_check
    $error("sync_serial_transmitter: unsupported WORD_W or FIFO_DEPTH");
  end

  logic [CTRL_W-1:0]  ctrl_q, ctrl_d;
  logic [EVT_W-1:0]   stat_q, stat_d, mask_q, mask_d;
  logic [31:0]        rdata_q, rdata_d;
  logic               burst_q, burst_d;
  logic [2:0]         bclk_s_q, fs_s_q;
  logic               bclk_int_q;
  logic [WORD_W-1:0]  mem_q [FIFO_DEPTH];
  logic [WORD_W-1:0]  mem_d [FIFO_DEPTH];
  logic [PTR_W-1:0]   wr_q, wr_d, rd_q, rd_d;
  logic [CNT_W-1:0]   count_q, count_d;
  tx_state_t          state_q, state_d;
  logic [WORD_W-1:0]  sr_q, sr_d, word_q, word_d;
  logic [BIT_W-1:0]   bit_q, bit_d;
  logic               dout_q, dout_d, fs_q, fs_d;
  logic               transmitter_reset_n_n, int_sync, int_clk, rise_en, fall_en, fs_seen;
  logic               apb_wr, mapped, push, pop, do_load, do_shift;
  logic               fifo_empty, fifo_full;
  logic [WORD_W-1:0]  head;

  assign transmitter_reset_n_n     = ctrl_q[CTRL_TRANSMITTER_RESET_N_N];
  assign int_sync   = ctrl_q[CTRL_SYNC_SRC];
  assign int_clk    = ctrl_q[CTRL_CLK_SRC];
  assign fifo_empty = (count_q == '0);
  assign fifo_full  = (count_q == CNT_FULL);
  assign head       = mem_q[rd_q];

  // Bit-clock edges: the internal clock toggles every system clock, the pin is synchronised first.
  assign rise_en = int_clk ? !bclk_int_q : (bclk_s_q[1] && !bclk_s_q[2]);
  assign fall_en = int_clk ? bclk_int_q : (!bclk_s_q[1] && bclk_s_q[2]);
  assign fs_seen = fs_s_q[1];

  // Pins; clock and sync are driven only when made inside.
  assign transmit_bit_clock_out  = bclk_int_q;
  assign transmit_bit_clock_oe   = int_clk;
  assign transmit_frame_sync_out = fs_q;
  assign transmit_frame_sync_oe  = int_sync;
  assign transmit_data_out       = dout_q;
  assign transmit_interrupt      = |(stat_q & mask_q);

  // APB decode; the slave never inserts wait states.
  assign apb_wr  = psel && penable && pwrite;
  assign mapped  = (paddr == ADDR_CTRL) || (paddr == ADDR_DATA) || (paddr == ADDR_STATUS)
                   || (paddr == ADDR_MASK);
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign prdata  = rdata_q;

  // Register file next values; read data is captured in the setup cycle.
  always_comb
  begin
    ctrl_d  = ctrl_q;
    mask_d  = mask_q;
    rdata_d = rdata_q;
    if (apb_wr && paddr == ADDR_CTRL)
      ctrl_d = pwdata[CTRL_W-1:0];
    if (apb_wr && paddr == ADDR_MASK)
      mask_d = pwdata[EVT_W-1:0];
    if (psel && !penable)
    begin
      rdata_d = 32'h0000_0000;
      if (paddr == ADDR_CTRL)
        rdata_d[CTRL_W-1:0] = ctrl_q;
      else if (paddr == ADDR_STATUS)
      begin
        rdata_d[EVT_W-1:0] = stat_q;
        rdata_d[STAT_COUNT_LSB +: CNT_W] = count_q;
        rdata_d[STAT_BUSY] = (state_q != ST_IDLE);
      end
      else if (paddr == ADDR_MASK)
        rdata_d[EVT_W-1:0] = mask_q;
    end
    // The framing mode follows the control bit only while the transmitter is held in reset.
    burst_d = transmitter_reset_n_n ? burst_q : ctrl_q[CTRL_FRAMING];
    // Events set their sticky bits; a set in the cycle of a clear wins.
    stat_d = stat_q;
    if (apb_wr && paddr == ADDR_STATUS)
      stat_d = stat_q & ~pwdata[EVT_W-1:0];
    if (pop && count_d == '0)
      stat_d[EVT_EMPTY] = 1'b1;
    if (apb_wr && paddr == ADDR_DATA && fifo_full)
      stat_d[EVT_DROP] = 1'b1;
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ctrl_q  <= CTRL_RESET;
      mask_q  <= EVT_RESET;
      stat_q  <= EVT_RESET;
      rdata_q <= 32'h0000_0000;
      burst_q <= 1'b0;
    end
    else
    begin
      ctrl_q  <= ctrl_d;
      mask_q  <= mask_d;
      stat_q  <= stat_d;
      rdata_q <= rdata_d;
      burst_q <= burst_d;
    end
  end

  // Pin synchronisers and the internal half-rate bit clock; stage 0 feeds only stage 1.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      bclk_s_q   <= 3'h0;
      fs_s_q     <= 3'h0;
      bclk_int_q <= 1'b0;
    end
    else
    begin
      bclk_s_q   <= {bclk_s_q[1:0], transmit_bit_clock_in};
      fs_s_q     <= {fs_s_q[1:0], transmit_frame_sync_in};
      bclk_int_q <= !bclk_int_q;
    end
  end

  // FIFO next values; a full FIFO discards the write and the transmitter reset flushes it.
  always_comb
  begin
    mem_d   = mem_q;
    wr_d    = wr_q;
    rd_d    = rd_q;
    push    = apb_wr && paddr == ADDR_DATA && !fifo_full && transmitter_reset_n_n;
    count_d = count_q + CNT_W'(push) - CNT_W'(pop);
    if (push)
    begin
      mem_d[wr_q] = pwdata[WORD_W-1:0];
      wr_d        = wr_q + 1'b1;
    end
    if (pop)
      rd_d = rd_q + 1'b1;
    if (!transmitter_reset_n_n)
    begin
      wr_d    = '0;
      rd_d    = '0;
      count_d = '0;
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      mem_q   <= '{default: '0};
      wr_q    <= '0;
      rd_q    <= '0;
      count_q <= '0;
    end
    else
    begin
      mem_q   <= mem_d;
      wr_q    <= wr_d;
      rd_q    <= rd_d;
      count_q <= count_d;
    end
  end

  // Transmit engine next values; all moves but the transmitter reset's return to ST_IDLE happen on bit-clock edge enables.
  always_comb
  begin
    state_d  = state_q;
    sr_d     = sr_q;
    word_d   = word_q;
    bit_d    = bit_q;
    dout_d   = dout_q;
    fs_d     = fs_q;
    do_load  = 1'b0;
    do_shift = 1'b0;
    if (!int_sync && fall_en && fs_seen)
    begin
      // A sync, even mid-word, arms the next word, or the last one again if none is queued.
      state_d = ST_ARMED;
      if (!fifo_empty)
      begin
        sr_d   = head;
        word_d = head;
      end
      else
        sr_d = word_q;
    end
    else if (rise_en)
    begin
      unique case (state_q)
        ST_IDLE:
          if (int_sync && !fifo_empty)
          begin
            fs_d    = 1'b1;
            state_d = ST_SYNC;
          end
        ST_SYNC:
          do_load = 1'b1;
        ST_ARMED:
        begin
          do_shift = 1'b1;
          bit_d    = BIT_LAST;
          state_d  = ST_SHIFT;
        end
        ST_SHIFT:
          if (bit_q != '0)
          begin
            do_shift = 1'b1;
            bit_d    = bit_q - 1'b1;
            // Burst internal sync: the next pulse rides alongside the last bit.
            if (bit_q == BIT_W'(1) && burst_q && int_sync && !fifo_empty)
              fs_d = 1'b1;
          end
          else if (!burst_q && !fifo_empty)
            do_load = 1'b1;
          else if (burst_q && int_sync && fs_q)
            do_load = 1'b1;
          else
            state_d = ST_IDLE;
      endcase
    end
    if (do_shift)
    begin
      dout_d = sr_q[WORD_W-1];
      sr_d   = {sr_q[WORD_W-2:0], 1'b0};
    end
    if (do_load)
    begin
      word_d  = head;
      dout_d  = head[WORD_W-1];
      sr_d    = {head[WORD_W-2:0], 1'b0};
      bit_d   = BIT_LAST;
      fs_d    = 1'b0;
      state_d = ST_SHIFT;
    end
    pop = (do_load || (state_d == ST_ARMED && state_q != ST_ARMED && !fifo_empty)
           || (state_q == ST_ARMED && state_d == ST_ARMED && !int_sync && fall_en && !fifo_empty));
    if (!transmitter_reset_n_n)
    begin
      state_d = ST_IDLE;
      fs_d    = 1'b0;
      pop     = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_q <= ST_IDLE;
      sr_q    <= '0;
      word_q  <= '0;
      bit_q   <= '0;
      dout_q  <= 1'b0;
      fs_q    <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      sr_q    <= sr_d;
      word_q  <= word_d;
      bit_q   <= bit_d;
      dout_q  <= dout_d;
      fs_q    <= fs_d;
    end
  end

  // Checks on the engine, FIFO and mode latch.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  mode_frozen_a: assert property (transmitter_reset_n_n && $past(transmitter_reset_n_n) |-> $stable(burst_q))
    else $error("framing mode changed while running");
  fifo_drop_a: assert property (apb_wr && paddr == ADDR_DATA && fifo_full && !pop |=> fifo_full)
    else $error("write to full FIFO changed it");
  empty_irq_a: assert property (pop && count_q == CNT_W'(1) && !push |=> stat_q[EVT_EMPTY])
    else $error("empty event not flagged");
  // The pulse must span one rise enable of the internal bit clock and drop right after it.
  sync_pulse_a: assert property (transmitter_reset_n_n && int_sync && int_clk && $rose(fs_q) |-> !rise_en
                                 ##1 (fs_q && rise_en) ##1 !fs_q)
    else $error("internal sync not one bit clock wide");
  load_msb_a: assert property (transmitter_reset_n_n && state_q == ST_SYNC && rise_en |=> state_q == ST_SHIFT
                               && dout_q == $past(head[WORD_W-1]) && !fs_q)
    else $error("internal sync load wrong");
  shift_step_a: assert property (transmitter_reset_n_n && state_q == ST_SHIFT && rise_en && bit_q != '0
                                 && !(!int_sync && fall_en) |=> bit_q == $past(bit_q) - 1'b1)
    else $error("bit counter did not step");
  cont_chain_a: assert property (transmitter_reset_n_n && !burst_q && state_q == ST_SHIFT && bit_q == '0 && rise_en
                                 && !fifo_empty |=> state_q == ST_SHIFT && bit_q == BIT_LAST && !fs_q)
    else $error("continuous run did not chain");
  burst_wait_a: assert property (transmitter_reset_n_n && burst_q && !int_sync && state_q == ST_SHIFT && bit_q == '0
                                 && rise_en |=> state_q == ST_IDLE)
    else $error("burst did not wait for sync");
  restart_a: assert property (transmitter_reset_n_n && !int_sync && fall_en && fs_seen |=> state_q == ST_ARMED)
    else $error("external sync did not restart");
  transmitter_reset_n_stop_a: assert property (!transmitter_reset_n_n |=> state_q == ST_IDLE && count_q == '0 && !fs_q)
    else $error("transmitter reset did not stop");
  // Both cycles must use the internal clock, or a switch to the pin would look like a stall.
  half_rate_a: assert property (int_clk && $past(int_clk) |-> rise_en != $past(rise_en))
    else $error("internal bit clock not half rate");

  chain_c: cover property (!burst_q && state_q == ST_SHIFT && bit_q == '0 && rise_en && !fifo_empty);
  resend_c: cover property (!int_sync && fall_en && fs_seen && fifo_empty && state_q == ST_SHIFT);
  drop_c: cover property (apb_wr && paddr == ADDR_DATA && fifo_full);

endmodule

// ===== dv/serial_peer.sv
`timescale 1ns/100ps
module serial_peer (
  // Pins from the transmitter.
  input  wire logic  transmit_bit_clock_out,
  input  wire logic  transmit_bit_clock_oe,
  input  wire logic  transmit_frame_sync_out,
  input  wire logic  transmit_frame_sync_oe,
  input  wire logic  transmit_data_out,
  // Clock enable from the bench.
  input  wire logic  run,
  // Pins driven by the peer.
  output logic       bit_clock,
  output logic       frame_sync
);
  logic        sample;
  logic        sync_seen;
  logic [15:0] shift;
  logic [15:0] words[$];
  int          nbits;
  int          syncs;

  // Sampling at our own rise is safe because the transmitter answers several system clocks late.
  assign sample    = transmit_bit_clock_oe ? ~transmit_bit_clock_out : bit_clock;
  assign sync_seen = transmit_frame_sync_oe ? transmit_frame_sync_out : frame_sync;

  // The link clock runs only when asked and always parks low between frames.
  initial
  begin
    bit_clock  = 1'b0;
    frame_sync = 1'b0;
    flush();
    #7;
    forever
    begin
      #160;
      if (run || bit_clock)
        bit_clock = ~bit_clock;
    end
  end

  // Bits gather MSB first; a sync restarts the word and drops any partial bits.
  always @(posedge sample)
  begin
    if (nbits >= 0)
    begin
      shift = {shift[14:0], transmit_data_out};
      nbits = nbits + 1;
      if (nbits == 16)
      begin
        words.push_back(shift);
        nbits = 0;
      end
    end
    if (sync_seen)
    begin
      syncs = syncs + 1;
      nbits = 0;
    end
  end

  // One pulse per word, dropped after one clock and kept low for the rest of the word.
  task automatic pulse_sync;
    @(posedge bit_clock);
    #1 frame_sync = 1'b1;
    @(posedge bit_clock);
    #1 frame_sync = 1'b0;
  endtask

  // Forget everything gathered so far.
  task automatic flush;
    words.delete();
    nbits = -1;
    syncs = 0;
  endtask
endmodule

// ===== dv/test_sync_serial_transmitter.sv
`timescale 1ns/100ps
module test_sync_serial_transmitter;
  import sst_pkg::*;
  typedef struct {logic [3:0] m; int n; int syncs;} row_t;
  logic        clk, reset_n, psel, penable, pwrite, pready, pslverr, run, slverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rsp;
  logic        bclk_out, bclk_oe, fs_out, fs_oe, dout, transmit_interrupt, peer_clk, peer_fs;
  logic [15:0] exp_q[$];
  int          err_count = 0;
  int          samples_checked = 0;
  // Internal clock and sync: continuous run, a fresh run after halt, then burst.
  row_t        rows[3] = '{'{4'he, 3, 1}, '{4'he, 1, 1}, '{4'hf, 2, 2}};

  // System clock.
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  sync_serial_transmitter DUT (
    .clk(clk), .reset_n(reset_n), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .transmit_bit_clock_in(peer_clk), .transmit_bit_clock_out(bclk_out), .transmit_bit_clock_oe(bclk_oe),
    .transmit_frame_sync_in(peer_fs), .transmit_frame_sync_out(fs_out), .transmit_frame_sync_oe(fs_oe),
    .transmit_data_out(dout), .transmit_interrupt(transmit_interrupt));

  serial_peer P (
    .transmit_bit_clock_out(bclk_out), .transmit_bit_clock_oe(bclk_oe), .transmit_frame_sync_out(fs_out),
    .transmit_frame_sync_oe(fs_oe), .transmit_data_out(dout), .run(run), .bit_clock(peer_clk),
    .frame_sync(peer_fs));

  function automatic logic [15:0] wd(input int j);
    return 16'h9c35 ^ 16'(j * 4681);
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One APB transfer; the request holds until pready is seen high at a rising edge.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
      @(posedge clk);
    while (pready !== 1'b1);
    rsp = prdata;
    slverr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic chk_rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rsp, e);
  endtask

  // Sampled mid-cycle so the write that just landed has settled.
  task automatic chk_irq(input logic e);
    @(negedge clk);
    chk({31'h0, transmit_interrupt}, {31'h0, e});
  endtask

  // Mode changes need the transmitter held in reset first.
  task automatic cfg(input logic [3:0] m);
    wr(ADDR_CTRL, {29'h0, m[2:0]});
    wr(ADDR_CTRL, {28'h0, m});
    P.flush();
  endtask

  task automatic wait_idle;
    int k;
    k = 0;
    do
    begin
      apb(1'b0, ADDR_STATUS, 32'h0);
      k++;
    end
    while ((rsp[STAT_COUNT_LSB +: 3] !== 3'h0 || rsp[STAT_BUSY] !== 1'b0) && k < 400);
    chk(32'(k < 400), 32'h1);
  endtask

  // Runs the link clock for one sync, an optional restart, then the given number of words.
  task automatic ext(input int restart_after, input int nw);
    @(posedge clk);
    run <= 1'b1;
    P.pulse_sync();
    if (restart_after > 0)
    begin
      repeat (restart_after) @(posedge peer_clk);
      P.pulse_sync();
    end
    repeat (16 * nw) @(posedge peer_clk);
    @(posedge clk);
    run <= 1'b0;
    repeat (12) @(posedge clk);
  endtask

  task automatic chk_rx;
    chk(32'(P.words.size() >= exp_q.size()), 32'h1);
    foreach (exp_q[i])
      if (i < P.words.size())
        chk({16'h0, P.words[i]}, {16'h0, exp_q[i]});
    exp_q.delete();
    P.flush();
  endtask

  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Main sequence: table rows first, then the awkward cases by hand.
  initial
  begin
    reset_n = 1'b0;
    {psel, penable, pwrite, paddr, pwdata, run} = '0;
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    chk_rd(ADDR_CTRL, 32'h0);
    chk_rd(ADDR_STATUS, 32'h0);
    apb(1'b0, 8'h10, 32'h0);
    chk({31'h0, slverr}, 32'h1);
    wr(ADDR_MASK, 32'h1);
    foreach (rows[i])
    begin
      if (i == 0 || rows[i].m != rows[i - 1].m)
        cfg(rows[i].m);
      for (int j = 0; j < rows[i].n; j++)
      begin
        wr(ADDR_DATA, {16'h0, wd(4 * i + j)});
        exp_q.push_back(wd(4 * i + j));
      end
      wait_idle();
      chk(32'(P.syncs), 32'(rows[i].syncs));
      chk_rx();
      chk({30'h0, bclk_oe, fs_oe}, 32'h3);
      chk_rd(ADDR_STATUS, 32'h1);
      chk_irq(1'b1);
      wr(ADDR_STATUS, 32'h1);
      chk_irq(1'b0);
    end
    cfg(4'h9);
    // The last control write lands at the edge the task returns on, so look mid-cycle.
    @(negedge clk);
    chk({30'h0, bclk_oe, fs_oe}, 32'h0);
    for (int j = 0; j < 5; j++)
      wr(ADDR_DATA, {16'h0, wd(j)});
    chk_rd(ADDR_STATUS, 32'h42);
    chk_irq(1'b0);
    wr(ADDR_MASK, 32'h3);
    chk_irq(1'b1);
    wr(ADDR_STATUS, 32'h2);
    for (int j = 0; j < 4; j++)
    begin
      ext(0, 1);
      exp_q.push_back(wd(j));
    end
    chk_rd(ADDR_STATUS, 32'h1);
    ext(0, 1);
    exp_q.push_back(wd(3));
    wr(ADDR_DATA, {16'h0, wd(5)});
    wr(ADDR_DATA, {16'h0, wd(6)});
    ext(6, 1);
    exp_q.push_back(wd(6));
    // With nothing queued, a mid-word restart must send the last armed word again.
    ext(6, 1);
    exp_q.push_back(wd(6));
    chk_rx();
    wr(ADDR_STATUS, 32'h3);
    wr(ADDR_DATA, {16'h0, wd(7)});
    wr(ADDR_DATA, {16'h0, wd(8)});
    // Flipping the framing bit outside transmitter reset must leave burst framing in force.
    wr(ADDR_CTRL, 32'h8);
    ext(0, 2);
    chk_rd(ADDR_STATUS, 32'h10);
    exp_q.push_back(wd(7));
    chk_rx();
    wr(ADDR_CTRL, 32'h0);
    wr(ADDR_DATA, {16'h0, wd(9)});
    chk_rd(ADDR_STATUS, 32'h0);
    cfg(4'h8);
    wr(ADDR_DATA, {16'h0, wd(10)});
    wr(ADDR_DATA, {16'h0, wd(11)});
    ext(0, 2);
    exp_q.push_back(wd(10));
    exp_q.push_back(wd(11));
    chk_rx();
    chk_rd(ADDR_STATUS, 32'h1);
    chk_irq(1'b1);
    end_of_test();
  end

  // The whole run needs about two thousand cycles; fifteen times that means a hang.
  initial
  begin
    repeat (30000) @(posedge clk);
    err_count++;
    end_of_test();
  end
endmodule
